// ---- hdl/bcu_pkg.sv ----
// constants, opcodes and state layout for the bit and carry instruction unit
// assumes one machine cycle per core_clk edge; operand fetch is done upstream
// Operation
// - bit set, clear, invert: 2 bytes, 1 cycle
// - jump on bit state: 3 bytes, 2 cycles
// - flags and carry settable, clearable, invertible, testable
// - 144 general flags: ram plus acc and b
// - mode bits reachable by bit address
// - add with carry updates carry; register form 1/1
// - subtract with borrow updates carry; indirect form 1/1
// - rotate left through carry, 1 byte 1 cycle
// - rotate right through carry, 1 byte 1 cycle
// - compare acc with direct, jump if unequal, 3/2
// - compare register with immediate, jump if unequal, 3/2
// - one-byte carry forms need no bit address
// - signed 8-bit displacement added to incremented pc
// - jump on bit then clear, same two-cycle instruction
package bcu_pkg;

  typedef enum logic [4:0] {
    BCU_OP_NOP        = 5'h00,
    BCU_OP_BIT_ONE    = 5'h01,
    BCU_OP_BIT_ZERO   = 5'h02,
    BCU_OP_BIT_INV    = 5'h03,
    BCU_OP_CY_ONE     = 5'h04,
    BCU_OP_CY_ZERO    = 5'h05,
    BCU_OP_CY_INV     = 5'h06,
    BCU_OP_JMP_ONE    = 5'h07,
    BCU_OP_JMP_ZERO   = 5'h08,
    BCU_OP_JMP_CLR    = 5'h09,
    BCU_OP_JMP_CY     = 5'h0a,
    BCU_OP_JMP_NCY    = 5'h0b,
    BCU_OP_ADD_CY     = 5'h0c,
    BCU_OP_SUB_BOR    = 5'h0d,
    BCU_OP_ROT_L      = 5'h0e,
    BCU_OP_ROT_R      = 5'h0f,
    BCU_OP_CMP_A_DIR  = 5'h10,
    BCU_OP_CMP_R_IMM  = 5'h11
  } bcu_op_t;

  typedef enum logic [1:0] {
    BCU_ST_IDLE  = 2'b01,
    BCU_ST_EXEC2 = 2'b10
  } bcu_state_t;

  // instruction lengths in bytes
  localparam logic [1:0] BCU_LEN_1 = 2'h1;
  localparam logic [1:0] BCU_LEN_2 = 2'h2;
  localparam logic [1:0] BCU_LEN_3 = 2'h3;

  // bit address map: below 0x80 is flag ram, above it register bytes
  localparam logic [4:0] BCU_BYTE_CTRL = 5'h11;  // bits 0x88..0x8f
  localparam logic [4:0] BCU_BYTE_PSW  = 5'h1a;  // bits 0xd0..0xd7
  localparam logic [4:0] BCU_BYTE_ACC  = 5'h1c;  // bits 0xe0..0xe7
  localparam logic [4:0] BCU_BYTE_B    = 5'h1e;  // bits 0xf0..0xf7
  localparam int unsigned BCU_RAM_BYTES = 16;

  // field positions
  localparam int unsigned BCU_PSW_CY      = 7;
  localparam int unsigned BCU_PSW_UFLAG0  = 5;
  localparam int unsigned BCU_CTRL_T0RUN  = 4;

  // reset values
  localparam logic [7:0] BCU_RST_BYTE   = 8'h00;
  localparam logic [15:0] BCU_RST_PC    = 16'h0000;

endpackage : bcu_pkg

// ---- hdl/bcu_alu.sv ----
// byte arithmetic for the carry-affecting instructions
// assumes operands already fetched; purely combinational
`timescale 1ns/1ps
`default_nettype none
module bcu_alu (
  input  wire bcu_pkg::bcu_op_t op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       src,
  input  wire logic [7:0]       imm,
  input  wire logic             cy_in,
  output logic      [7:0]       res,
  output logic                  cy_out,
  output logic                  not_equal
);
  import bcu_pkg::*;

  logic [8:0] sum;
  logic [8:0] diff;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;

  always_comb begin
    sum    = {1'b0, acc} + {1'b0, src} + {8'h00, cy_in};
    diff   = {1'b0, acc} - {1'b0, src} - {8'h00, cy_in};
    // register form compares source with immediate, else acc with source
    cmp_a  = (op == BCU_OP_CMP_R_IMM) ? src : acc;
    cmp_b  = (op == BCU_OP_CMP_R_IMM) ? imm : src;
    not_equal = (cmp_a != cmp_b);
    res    = acc;
    cy_out = cy_in;
    case (op)
      BCU_OP_ADD_CY: begin
        res    = sum[7:0];
        cy_out = sum[8];
      end
      BCU_OP_SUB_BOR: begin
        res    = diff[7:0];
        cy_out = diff[8];
      end
      BCU_OP_ROT_L: begin
        res    = {acc[6:0], cy_in};
        cy_out = acc[7];
      end
      BCU_OP_ROT_R: begin
        res    = {cy_in, acc[7:1]};
        cy_out = acc[0];
      end
      BCU_OP_CMP_A_DIR, BCU_OP_CMP_R_IMM: begin
        cy_out = (cmp_a < cmp_b);
      end
      default: begin
        res    = acc;
        cy_out = cy_in;
      end
    endcase
  end

endmodule : bcu_alu
`default_nettype wire

// ---- hdl/bcu_core.sv ----
// execution unit for single-bit instructions and carry-affecting byte ops
// assumes decode and operand fetch upstream; one machine cycle per core_clk edge
`timescale 1ns/1ps
`default_nettype none
module bcu_core (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             issue_valid,
  input  wire bcu_pkg::bcu_op_t issue_op,
  input  wire logic [7:0]       issue_bit,
  input  wire logic [7:0]       issue_src,
  input  wire logic [7:0]       issue_imm,
  input  wire logic [7:0]       issue_rel,
  input  wire logic [15:0]      issue_pc,
  output logic                  busy,
  output logic                  done,
  output logic      [1:0]       instr_len,
  output logic                  jump_taken,
  output logic      [15:0]      jump_target,
  output logic      [7:0]       acc,
  output logic      [7:0]       b_reg,
  output logic      [7:0]       psw,
  output logic      [7:0]       mode_ctrl,
  output logic                  carry,
  output logic                  user_flag_zero,
  output logic                  timer0_run_flag
);
  import bcu_pkg::*;

  typedef struct packed {
    bcu_state_t       st;
    logic [15:0][7:0] ram;
    logic [7:0]       acc;
    logic [7:0]       b;
    logic [7:0]       psw;
    logic [7:0]       ctrl;
    logic             busy;
    logic             done;
    logic [1:0]       len;
    logic             taken;
    logic             jmp_rep;
    logic [15:0]      target;
  } bcu_regs_t;

  localparam bcu_regs_t BCU_RST = '{
    st:     BCU_ST_IDLE,
    ram:    '0,
    acc:    BCU_RST_BYTE,
    b:      BCU_RST_BYTE,
    psw:    BCU_RST_BYTE,
    ctrl:   BCU_RST_BYTE,
    busy:   1'b0,
    done:   1'b0,
    len:    2'h0,
    taken:  1'b0,
    jmp_rep: 1'b0,
    target: BCU_RST_PC
  };

  bcu_regs_t regs_r;
  bcu_regs_t regs_nxt;

  logic [7:0] alu_res;
  logic       alu_cy;
  logic       alu_ne;

  // read one bit from the flat bit space; unmapped register bits read zero
  function automatic logic bit_get(input bcu_regs_t s, input logic [7:0] a);
    logic v;
    v = 1'b0;
    if (!a[7]) begin
      v = s.ram[a[6:3]][a[2:0]];
    end else begin
      case (a[7:3])
        BCU_BYTE_CTRL: v = s.ctrl[a[2:0]];
        BCU_BYTE_PSW:  v = s.psw[a[2:0]];
        BCU_BYTE_ACC:  v = s.acc[a[2:0]];
        BCU_BYTE_B:    v = s.b[a[2:0]];
        default:       v = 1'b0;
      endcase
    end
    return v;
  endfunction : bit_get

  // write one bit; writes to unmapped register bits are dropped
  function automatic bcu_regs_t bit_put(input bcu_regs_t s, input logic [7:0] a, input logic v);
    bcu_regs_t t;
    t = s;
    if (!a[7]) begin
      t.ram[a[6:3]][a[2:0]] = v;
    end else begin
      case (a[7:3])
        BCU_BYTE_CTRL: t.ctrl[a[2:0]] = v;
        BCU_BYTE_PSW:  t.psw[a[2:0]]  = v;
        BCU_BYTE_ACC:  t.acc[a[2:0]]  = v;
        BCU_BYTE_B:    t.b[a[2:0]]    = v;
        default:       t = s;
      endcase
    end
    return t;
  endfunction : bit_put

  // sign-extended displacement onto the incremented pc
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] rel);
    return pc + {{8{rel[7]}}, rel};
  endfunction : rel_target

  bcu_alu u_alu (
    .op        (issue_op),
    .acc       (regs_r.acc),
    .src       (issue_src),
    .imm       (issue_imm),
    .cy_in     (regs_r.psw[BCU_PSW_CY]),
    .res       (alu_res),
    .cy_out    (alu_cy),
    .not_equal (alu_ne)
  );

  always_comb begin
    logic bv;
    logic go;
    bv       = bit_get(regs_r, issue_bit);
    go       = issue_valid && !regs_r.busy;
    regs_nxt = regs_r;
    regs_nxt.done = 1'b0;
    regs_nxt.jmp_rep = 1'b0;
    case (regs_r.st)
      BCU_ST_IDLE: begin
        if (go) begin
          regs_nxt.taken  = 1'b0;
          regs_nxt.target = issue_pc;
          case (issue_op)
            BCU_OP_BIT_ONE: begin
              regs_nxt      = bit_put(regs_nxt, issue_bit, 1'b1);
              regs_nxt.len  = BCU_LEN_2;
              regs_nxt.done = 1'b1;
            end
            BCU_OP_BIT_ZERO: begin
              regs_nxt      = bit_put(regs_nxt, issue_bit, 1'b0);
              regs_nxt.len  = BCU_LEN_2;
              regs_nxt.done = 1'b1;
            end
            BCU_OP_BIT_INV: begin
              regs_nxt      = bit_put(regs_nxt, issue_bit, ~bv);
              regs_nxt.len  = BCU_LEN_2;
              regs_nxt.done = 1'b1;
            end
            BCU_OP_CY_ONE: begin
              regs_nxt.psw[BCU_PSW_CY] = 1'b1;
              regs_nxt.len  = BCU_LEN_1;
              regs_nxt.done = 1'b1;
            end
            BCU_OP_CY_ZERO: begin
              regs_nxt.psw[BCU_PSW_CY] = 1'b0;
              regs_nxt.len  = BCU_LEN_1;
              regs_nxt.done = 1'b1;
            end
            BCU_OP_CY_INV: begin
              regs_nxt.psw[BCU_PSW_CY] = ~regs_r.psw[BCU_PSW_CY];
              regs_nxt.len  = BCU_LEN_1;
              regs_nxt.done = 1'b1;
            end
            BCU_OP_JMP_ONE, BCU_OP_JMP_ZERO: begin
              // decision latched now, reported when the second cycle ends
              regs_nxt.taken = (issue_op == BCU_OP_JMP_ONE) ? bv : ~bv;
              regs_nxt.len   = BCU_LEN_3;
              regs_nxt.busy  = 1'b1;
              regs_nxt.st    = BCU_ST_EXEC2;
            end
            BCU_OP_JMP_CLR: begin
              regs_nxt.taken = bv;
              if (bv) begin
                regs_nxt = bit_put(regs_nxt, issue_bit, 1'b0);
              end
              regs_nxt.len  = BCU_LEN_3;
              regs_nxt.busy = 1'b1;
              regs_nxt.st   = BCU_ST_EXEC2;
            end
            BCU_OP_JMP_CY, BCU_OP_JMP_NCY: begin
              regs_nxt.taken = (issue_op == BCU_OP_JMP_CY) ? regs_r.psw[BCU_PSW_CY]
                                                           : ~regs_r.psw[BCU_PSW_CY];
              regs_nxt.len  = BCU_LEN_2;
              regs_nxt.busy = 1'b1;
              regs_nxt.st   = BCU_ST_EXEC2;
            end
            BCU_OP_ADD_CY, BCU_OP_SUB_BOR, BCU_OP_ROT_L, BCU_OP_ROT_R: begin
              regs_nxt.acc             = alu_res;
              regs_nxt.psw[BCU_PSW_CY] = alu_cy;
              regs_nxt.len             = BCU_LEN_1;
              regs_nxt.done            = 1'b1;
            end
            BCU_OP_CMP_A_DIR, BCU_OP_CMP_R_IMM: begin
              regs_nxt.psw[BCU_PSW_CY] = alu_cy;
              regs_nxt.taken = alu_ne;
              regs_nxt.len   = BCU_LEN_3;
              regs_nxt.busy  = 1'b1;
              regs_nxt.st    = BCU_ST_EXEC2;
            end
            default: begin
              regs_nxt.len  = BCU_LEN_1;
              regs_nxt.done = 1'b1;
            end
          endcase
          // a branch not taken reports the fall-through address
          if (regs_nxt.busy && regs_nxt.taken) begin
            regs_nxt.target = rel_target(issue_pc, issue_rel);
          end
        end
      end
      BCU_ST_EXEC2: begin
        // second machine cycle of every conditional jump
        regs_nxt.busy = 1'b0;
        regs_nxt.done = 1'b1;
        regs_nxt.st   = BCU_ST_IDLE;
        // registered so jump_taken rises with done, not during busy
        regs_nxt.jmp_rep = regs_r.taken;
      end
      default: begin
        regs_nxt = BCU_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regs_r <= BCU_RST;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // every output is a slice of the one state register
  always_comb begin
    busy            = regs_r.busy;
    done            = regs_r.done;
    instr_len       = regs_r.len;
    jump_taken      = regs_r.jmp_rep;
    jump_target     = regs_r.target;
    acc             = regs_r.acc;
    b_reg           = regs_r.b;
    psw             = regs_r.psw;
    mode_ctrl       = regs_r.ctrl;
    carry           = regs_r.psw[BCU_PSW_CY];
    user_flag_zero  = regs_r.psw[BCU_PSW_UFLAG0];
    timer0_run_flag = regs_r.ctrl[BCU_CTRL_T0RUN];
  end

endmodule : bcu_core
`default_nettype wire

// ---- dv/bcu_core_asserts.sv ----
// checker for bcu_core: timing, lengths and carry arithmetic
// bound from the testbench top; sees core ports only
`timescale 1ns/1ps
`default_nettype none
module bcu_core_chk (
  input wire logic             core_clk,
  input wire logic             sys_rst,
  input wire logic             issue_valid,
  input wire bcu_pkg::bcu_op_t issue_op,
  input wire logic [7:0]       issue_src,
  input wire logic [7:0]       issue_rel,
  input wire logic [15:0]      issue_pc,
  input wire logic             busy,
  input wire logic             done,
  input wire logic [1:0]       instr_len,
  input wire logic             jump_taken,
  input wire logic [15:0]      jump_target,
  input wire logic [7:0]       acc,
  input wire logic             carry
);
  import bcu_pkg::*;
  logic tk;
  assign tk = issue_valid && !busy;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_bit_timing: assert property (tk && issue_op inside {BCU_OP_BIT_ONE, BCU_OP_BIT_ZERO, BCU_OP_BIT_INV}
    |=> done && !busy && instr_len == BCU_LEN_2) else $error("bit op timing wrong");
  chk_carry_one: assert property (tk && issue_op == BCU_OP_CY_ONE
    |=> done && carry && instr_len == BCU_LEN_1) else $error("carry set wrong");
  chk_carry_inv: assert property (tk && issue_op == BCU_OP_CY_INV
    |=> carry != $past(carry)) else $error("carry invert wrong");
  chk_jump_timing: assert property (tk && issue_op inside {BCU_OP_JMP_ONE, BCU_OP_JMP_ZERO, BCU_OP_JMP_CLR}
    |=> busy ##1 (done && !busy && instr_len == BCU_LEN_3)) else $error("jump timing wrong");
  chk_cmp_timing: assert property (tk && issue_op inside {BCU_OP_CMP_A_DIR, BCU_OP_CMP_R_IMM}
    |=> busy ##1 (done && instr_len == BCU_LEN_3)) else $error("compare timing wrong");
  chk_add_carry: assert property (tk && issue_op == BCU_OP_ADD_CY
    |=> done && instr_len == BCU_LEN_1
        && {carry, acc} == 9'($past(acc)) + 9'($past(issue_src)) + 9'($past(carry)))
    else $error("add with carry wrong");
  chk_sub_borrow: assert property (tk && issue_op == BCU_OP_SUB_BOR
    |=> {carry, acc} == 9'($past(acc)) - 9'($past(issue_src)) - 9'($past(carry)))
    else $error("subtract with borrow wrong");
  chk_rot_left: assert property (tk && issue_op == BCU_OP_ROT_L
    |=> {carry, acc} == {$past(acc), $past(carry)}) else $error("rotate left wrong");
  chk_rot_right: assert property (tk && issue_op == BCU_OP_ROT_R
    |=> {acc, carry} == {$past(carry), $past(acc)}) else $error("rotate right wrong");
  chk_jump_target: assert property (done && jump_taken
    |-> jump_target == $past(issue_pc, 2) + 16'($signed($past(issue_rel, 2))))
    else $error("jump target wrong");
endmodule : bcu_core_chk
`default_nettype wire

// ---- dv/tb_bcu_core.sv ----
// self-checking bench for bcu_core
// drives the issue port directly; checker bound below
`timescale 1ns/1ps
`default_nettype none
module tb_bcu_core;
  import bcu_pkg::*;
  logic        core_clk, sys_rst, issue_valid;
  bcu_op_t     issue_op;
  logic [7:0]  issue_bit, issue_src, issue_imm, issue_rel;
  logic [15:0] issue_pc, jump_target;
  logic        busy, done, jump_taken, carry, user_flag_zero, timer0_run_flag;
  logic [1:0]  instr_len;
  logic [7:0]  acc, b_reg, psw, mode_ctrl;
  int          mismatches, checks_done;

  bcu_core DUT (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .issue_valid     (issue_valid),
    .issue_op        (issue_op),
    .issue_bit       (issue_bit),
    .issue_src       (issue_src),
    .issue_imm       (issue_imm),
    .issue_rel       (issue_rel),
    .issue_pc        (issue_pc),
    .busy            (busy),
    .done            (done),
    .instr_len       (instr_len),
    .jump_taken      (jump_taken),
    .jump_target     (jump_target),
    .acc             (acc),
    .b_reg           (b_reg),
    .psw             (psw),
    .mode_ctrl       (mode_ctrl),
    .carry           (carry),
    .user_flag_zero  (user_flag_zero),
    .timer0_run_flag (timer0_run_flag)
  );

  task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
    checks_done++;
    if (got !== ex) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  // issue once, count edges to done, then check length
  task automatic run(bcu_op_t op, int cy, logic [1:0] ln, logic [7:0] bt = 8'h00,
                     logic [7:0] s = 8'h00, logic [7:0] im = 8'h00, logic [7:0] r = 8'h00);
    int n;
    @(posedge core_clk);
    issue_valid <= 1'b1;
    issue_op    <= op;
    issue_bit   <= bt;
    issue_src   <= s;
    issue_imm   <= im;
    issue_rel   <= r;
    @(posedge core_clk);
    issue_valid <= 1'b0;
    n = 1;
    #1;
    while (done !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("cycles", 16'(cy), 16'(n));
    chk("length", 16'(ln), 16'(instr_len));
  endtask : run

  task automatic jmp(bcu_op_t op, logic [7:0] bt, s, im, r, logic tk, logic [15:0] tg,
                     logic [1:0] ln = BCU_LEN_3);
    run(op, 2, ln, bt, s, im, r);
    chk("taken", 16'(tk), 16'(jump_taken));
    chk("target", tg, jump_target);
  endtask : jmp

  task automatic t_bits;
    run(BCU_OP_BIT_ONE, 1, BCU_LEN_2, 8'he3);
    chk("acc", 16'h0008, 16'(acc));
    run(BCU_OP_BIT_INV, 1, BCU_LEN_2, 8'he0);
    chk("acc", 16'h0009, 16'(acc));
    run(BCU_OP_BIT_ZERO, 1, BCU_LEN_2, 8'he3);
    chk("acc", 16'h0001, 16'(acc));
    run(BCU_OP_BIT_ONE, 1, BCU_LEN_2, 8'hf7);
    chk("b_reg", 16'h0080, 16'(b_reg));
    run(BCU_OP_BIT_ONE, 1, BCU_LEN_2, 8'h8c);
    chk("timer0_run", 16'h0001, 16'(timer0_run_flag));
    run(BCU_OP_BIT_INV, 1, BCU_LEN_2, 8'h8c);
    chk("mode_ctrl", 16'h0000, 16'(mode_ctrl));
    run(BCU_OP_BIT_ONE, 1, BCU_LEN_2, 8'hd5);
    chk("user_flag", 16'h0001, 16'(user_flag_zero));
  endtask : t_bits

  task automatic t_carry;
    run(BCU_OP_CY_ONE, 1, BCU_LEN_1);
    chk("carry", 16'h0001, 16'(carry));
    run(BCU_OP_CY_INV, 1, BCU_LEN_1);
    chk("carry", 16'h0000, 16'(carry));
    run(BCU_OP_BIT_INV, 1, BCU_LEN_2, 8'hd7);
    chk("carry", 16'h0001, 16'(carry));
    run(BCU_OP_CY_ZERO, 1, BCU_LEN_1);
    chk("carry", 16'h0000, 16'(carry));
    jmp(BCU_OP_JMP_ZERO, 8'hd7, 8'h00, 8'h00, 8'h04, 1'b1, 16'h1004);
    run(BCU_OP_BIT_ONE, 1, BCU_LEN_2, 8'hd7);
    jmp(BCU_OP_JMP_ONE, 8'hd7, 8'h00, 8'h00, 8'h04, 1'b1, 16'h1004);
    jmp(BCU_OP_JMP_CY, 8'h00, 8'h00, 8'h00, 8'h10, 1'b1, 16'h1010, BCU_LEN_2);
    jmp(BCU_OP_JMP_NCY, 8'h00, 8'h00, 8'h00, 8'h10, 1'b0, 16'h1000, BCU_LEN_2);
    run(BCU_OP_NOP, 1, BCU_LEN_1);
    chk("carry", 16'h0001, 16'(carry));
  endtask : t_carry

  task automatic t_jumps;
    run(BCU_OP_BIT_ONE, 1, BCU_LEN_2, 8'h7f);
    jmp(BCU_OP_JMP_ONE, 8'h7f, 8'h00, 8'h00, 8'h80, 1'b1, 16'h0f80);
    jmp(BCU_OP_JMP_ZERO, 8'h7f, 8'h00, 8'h00, 8'h7f, 1'b0, 16'h1000);
    jmp(BCU_OP_JMP_ZERO, 8'h00, 8'h00, 8'h00, 8'h7f, 1'b1, 16'h107f);
    jmp(BCU_OP_JMP_CLR, 8'h7f, 8'h00, 8'h00, 8'h02, 1'b1, 16'h1002);
    jmp(BCU_OP_JMP_ONE, 8'h7f, 8'h00, 8'h00, 8'h02, 1'b0, 16'h1000);
    jmp(BCU_OP_JMP_CLR, 8'h7f, 8'h00, 8'h00, 8'h02, 1'b0, 16'h1000);
  endtask : t_jumps

  // acc 01, carry 1 on entry
  task automatic t_arith;
    run(BCU_OP_ADD_CY, 1, BCU_LEN_1, 8'h00, 8'h7e);
    chk("cy_acc", 16'h0080, {7'h00, carry, acc});
    run(BCU_OP_ROT_L, 1, BCU_LEN_1);
    chk("cy_acc", 16'h0100, {7'h00, carry, acc});
    run(BCU_OP_ROT_R, 1, BCU_LEN_1);
    chk("cy_acc", 16'h0080, {7'h00, carry, acc});
    run(BCU_OP_SUB_BOR, 1, BCU_LEN_1, 8'h00, 8'h81);
    chk("cy_acc", 16'h01ff, {7'h00, carry, acc});
    run(BCU_OP_ADD_CY, 1, BCU_LEN_1, 8'h00, 8'hfe);
    chk("cy_acc", 16'h01fe, {7'h00, carry, acc});
    run(BCU_OP_SUB_BOR, 1, BCU_LEN_1, 8'h00, 8'h0f);
    chk("cy_acc", 16'h00ee, {7'h00, carry, acc});
  endtask : t_arith

  task automatic t_cmp;
    jmp(BCU_OP_CMP_A_DIR, 8'h00, 8'hef, 8'h00, 8'h10, 1'b1, 16'h1010);
    chk("carry", 16'h0001, 16'(carry));
    jmp(BCU_OP_CMP_A_DIR, 8'h00, 8'hee, 8'h00, 8'h10, 1'b0, 16'h1000);
    chk("carry", 16'h0000, 16'(carry));
    jmp(BCU_OP_CMP_R_IMM, 8'h00, 8'h03, 8'h05, 8'hfe, 1'b1, 16'h0ffe);
    chk("carry", 16'h0001, 16'(carry));
    jmp(BCU_OP_CMP_R_IMM, 8'h00, 8'h05, 8'h05, 8'hfe, 1'b0, 16'h1000);
    chk("carry", 16'h0000, 16'(carry));
  endtask : t_cmp

  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // 34 ops of at most 5 edges each
  initial begin
    repeat (2000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    issue_valid = 1'b0;
    issue_op = BCU_OP_NOP;
    {issue_bit, issue_src, issue_imm, issue_rel} = 32'h0000_0000;
    issue_pc = 16'h1000;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_bits();
    t_carry();
    t_jumps();
    t_arith();
    t_cmp();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("state", 16'h0000, {acc, psw});
    end_sim();
  end
endmodule : tb_bcu_core

bind bcu_core bcu_core_chk u_chk (
  .core_clk    (core_clk),
  .sys_rst     (sys_rst),
  .issue_valid (issue_valid),
  .issue_op    (issue_op),
  .issue_src   (issue_src),
  .issue_rel   (issue_rel),
  .issue_pc    (issue_pc),
  .busy        (busy),
  .done        (done),
  .instr_len   (instr_len),
  .jump_taken  (jump_taken),
  .jump_target (jump_target),
  .acc         (acc),
  .carry       (carry)
);
`default_nettype wire
